// >>> core/une_pkg.sv
// Summary of operation
// - Two-bit field selects the node state
// - Module reset enters bus reset, pipes disabled
// - Suspend: low-power transceivers, endpoint logic frozen
// - Resume flag set on resume while suspended
// - Warning summary set by unmasked warning, read-clears
// - Bus-condition summary set by unmasked event
// - Transmit summary tracks unmasked transmit events
// - Frame flag on every frame counter update
// - NAK summary set by unmasked NAK event
// - Lock-change flag on unlocked status change
// - Receive summary tracks unmasked receive events
// - Main bit 7 reads zero; mask bit 7 enables
// - Only masked-in main events interrupt; masks reset 0
// - Idle 3 ms sets flag, clears on read
// - Idle 5 ms sets flag, clears on read
// - SE0 for 2.5 us sets bus-reset flag
// - Valid end of packet sets its flag
// - Bus-condition events set regardless of mask; mask bits gate only the summary
// - Revision nibble read-only, upper bits reserved
// - Clear-on-read bits clear on firmware read
package une_pkg;
  // Clock rate
  localparam int CLK_KHZ = 20000;
  localparam int CLK_NS = 50;
  // Idle and SE0 times, in their own units
  localparam int IDLE3_MS = 3;
  localparam int IDLE5_MS = 5;
  localparam int SE0_NS = 2500;
  // Cycle counts; least times round up
  localparam int IDLE3_CYC = IDLE3_MS * CLK_KHZ;
  localparam int IDLE5_CYC = IDLE5_MS * CLK_KHZ;
  localparam int SE0_CYC = (SE0_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;
  localparam int SE0_W = 7;
  // Register byte addresses
  localparam logic [7:0] A_REV = 8'h00;
  localparam logic [7:0] A_NFS = 8'h04;
  localparam logic [7:0] A_MEV = 8'h08;
  localparam logic [7:0] A_MMSK = 8'h0C;
  localparam logic [7:0] A_ALT = 8'h10;
  localparam logic [7:0] A_AMSK = 8'h14;
  localparam logic [7:0] A_TX = 8'h18;
  localparam logic [7:0] A_TMSK = 8'h1C;
  localparam logic [7:0] A_RX = 8'h20;
  localparam logic [7:0] A_RMSK = 8'h24;
  localparam logic [7:0] A_NAK = 8'h28;
  localparam logic [7:0] A_NMSK = 8'h2C;
  localparam logic [7:0] A_FW = 8'h30;
  localparam logic [7:0] A_FMSK = 8'h34;
  // Field layout
  localparam int NFS_LSB = 0;
  localparam int MB_MIE = 7;
  localparam logic [7:0] ALT_BITS = 8'hF8;
  localparam logic [7:0] TX_BITS = 8'hEF;
  localparam logic [7:0] FW_BITS = 8'hEE;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Revision value, arbitrary
  localparam logic [3:0] REV_ID = 4'h7;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Node states, codes fixed by the field
  typedef enum logic [1:0] {
    state_bus_reset = 2'h0,
    state_wakeup_signalling = 2'h1,
    state_operational = 2'h2,
    state_suspend = 2'h3
  } une_node_e;
  // Upstream line conditions from the transceiver
  typedef struct packed {
    logic idle;
    logic se0;
    logic resume_k;
    logic eop;
  } une_line_s;
  // Node controls to transceiver and endpoints
  typedef struct packed {
    logic ep_disable;
    logic ep_freeze;
    logic xcvr_suspend;
    logic drive_k;
  } une_node_s;
endpackage

// >>> core/une_top.sv
`timescale 1ns/1ns
`default_nettype none
module une_top import une_pkg::*; #(
  parameter int IDLE3_CYC_P = IDLE3_CYC, // 3 ms idle count
  parameter int IDLE5_CYC_P = IDLE5_CYC // 5 ms idle count
) (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire une_line_s line_in, // Async line conditions
  input wire logic frame_update, // Frame counter updated
  input wire logic frame_unlocked_status, // Frame timer unlocked
  input wire logic [7:0] transmit_event_in, // Underrun, done copies
  input wire logic [3:0] receive_last_in, // Receive-last copies
  input wire logic [3:0] receive_overrun_pulse, // Overrun events
  input wire logic [7:0] nak_pulse, // OUT, IN NAK events
  input wire logic [7:0] fifo_warn_in, // Warning levels
  output logic [1:0] node_state_field, // Current node state
  output une_node_s node_ctl, // Node controls
  output logic irq // Interrupt, high
);
  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q, wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Block state
  une_node_e nfs_q;
  une_node_s ctl_q;
  logic [7:0] mev_q, mmsk_q, bus_condition_event_q, amsk_q;
  logic [7:0] tmsk_q, rmsk_q, nakev_q, nmsk_q, fmsk_q;
  logic [3:0] rxovr_q;
  logic [7:0] fw_prev_q;
  logic ul_prev_q, irq_q;
  // Line synchroniser, edge stage
  une_line_s line_s1_q, line_s2_q, line_s3_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic [SE0_W-1:0] se0_cnt_q;

  // Handshakes
  wire aw_fire = awvalid & awready_q;
  wire w_fire = wvalid & wready_q;
  wire b_fire = bvalid_q & bready;
  wire ar_fire = arvalid & arready_q;
  wire r_fire = rvalid_q & rready;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_ok = wr_go & wlane_q; // Upper lanes ignored

  // Write decode
  wire ws_nfs = wr_ok & (awaddr_q == A_NFS);
  wire ws_mmsk = wr_ok & (awaddr_q == A_MMSK);
  wire ws_amsk = wr_ok & (awaddr_q == A_AMSK);
  wire ws_tmsk = wr_ok & (awaddr_q == A_TMSK);
  wire ws_rmsk = wr_ok & (awaddr_q == A_RMSK);
  wire ws_nmsk = wr_ok & (awaddr_q == A_NMSK);
  wire ws_fmsk = wr_ok & (awaddr_q == A_FMSK);
  wire wr_map = ((awaddr_q <= A_FMSK) && (awaddr_q[1:0] == 2'h0));

  // Read decode; side effects fire on address handshake
  wire rd_map = ((araddr <= A_FMSK) && (araddr[1:0] == 2'h0));
  wire mev_rd = ar_fire & (araddr == A_MEV);
  wire alt_rd = ar_fire & (araddr == A_ALT);
  wire rx_rd = ar_fire & (araddr == A_RX);
  wire nak_rd = ar_fire & (araddr == A_NAK);
  wire fw_rd = ar_fire & (araddr == A_FW);

  // Event sources
  wire [7:0] tx_lvl = transmit_event_in & TX_BITS;
  wire [7:0] rx_lvl = {rxovr_q, receive_last_in};
  wire [7:0] fw_lvl = fifo_warn_in & FW_BITS;
  wire [7:0] fw_new = fw_lvl & ~fw_prev_q & fmsk_q;
  wire in_susp = (nfs_q == state_suspend);
  wire res_hit = line_s2_q.resume_k & ~line_s3_q.resume_k & in_susp;
  wire eop_hit = line_s2_q.eop & ~line_s3_q.eop;
  wire sd3_hit = line_s2_q.idle & (idle_cnt_q == CNT_W'(IDLE3_CYC_P - 1));
  wire sd5_hit = line_s2_q.idle & (idle_cnt_q == CNT_W'(IDLE5_CYC_P - 1));
  wire rst_hit = line_s2_q.se0 & (se0_cnt_q == SE0_W'(SE0_CYC - 1));
  wire [7:0] alt_set = {res_hit, rst_hit, sd5_hit, sd3_hit, eop_hit, 3'h0} & ALT_BITS;
  wire [7:0] alt_new = alt_set & amsk_q;

  // Main event next value; set beats clear
  wire [7:0] m_set = {2'h0, ul_prev_q ^ frame_unlocked_status,
                      |(nak_pulse & nmsk_q), frame_update, 1'h0,
                      |alt_new, |fw_new};
  wire [7:0] m_clr = {2'h0, mev_rd, nak_rd, mev_rd, 1'h0, alt_rd, fw_rd};
  wire [7:0] m_keep = (mev_q & ~m_clr) | m_set;
  wire tx_term = (|(tx_lvl & tmsk_q)) | (mev_q[2] & (|tx_lvl));
  wire rx_term = (|(rx_lvl & rmsk_q)) | (mev_q[6] & (|rx_lvl));
  wire [7:0] mev_d = {1'h0, rx_term, m_keep[5:3], tx_term, m_keep[1:0]};
  wire [7:0] bus_condition_event_d = (bus_condition_event_q & ~{8{alt_rd}}) | alt_set;
  wire [7:0] nakev_d = (nakev_q & ~{8{nak_rd}}) | nak_pulse;
  wire [3:0] rxovr_d = (rxovr_q & ~{4{rx_rd}}) | receive_overrun_pulse;

  // Node state next value
  wire [1:0] nfs_raw = wbyte_q[NFS_LSB +: 2];
  wire une_node_e nfs_d = ws_nfs ? une_node_e'(nfs_raw) : nfs_q;

  // Read data selection; reserved bits read zero
  wire [7:0] rd_byte =
    (araddr == A_REV) ? {4'h0, REV_ID} :
    (araddr == A_NFS) ? {6'h00, nfs_q} :
    (araddr == A_MEV) ? mev_q :
    (araddr == A_MMSK) ? mmsk_q :
    (araddr == A_ALT) ? bus_condition_event_q :
    (araddr == A_AMSK) ? amsk_q :
    (araddr == A_TX) ? tx_lvl :
    (araddr == A_TMSK) ? tmsk_q :
    (araddr == A_RX) ? rx_lvl :
    (araddr == A_RMSK) ? rmsk_q :
    (araddr == A_NAK) ? nakev_q :
    (araddr == A_NMSK) ? nmsk_q :
    (araddr == A_FW) ? fw_lvl :
    (araddr == A_FMSK) ? fmsk_q : RST_BYTE;

  // Write channels; address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
      awaddr_q <= RST_BYTE;
      wbyte_q <= RST_BYTE;
      wlane_q <= 1'b0;
    end else begin
      if (aw_fire) begin
        awaddr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_fire) begin
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        // Unmapped writes answer SLVERR
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OK : RESP_ERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (b_fire) begin
        // Reopen only after response, one write at a time
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel; data sampled with the clear, so nothing is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OK;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_map ? RESP_OK : RESP_ERR;
    end else if (r_fire) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Line pins cross in through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_s1_q <= '0;
      line_s2_q <= '0;
      line_s3_q <= '0;
    end else begin
      line_s1_q <= line_in;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q;
    end
  end

  // Idle timer saturates at 5 ms so each flag fires once per idle spell
  always_ff @(posedge aclk) begin
    if (!aresetn || !line_s2_q.idle) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != CNT_W'(IDLE5_CYC_P)) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // SE0 timer for bus reset detection
  always_ff @(posedge aclk) begin
    if (!aresetn || !line_s2_q.se0) begin
      se0_cnt_q <= '0;
    end else if (se0_cnt_q != SE0_W'(SE0_CYC)) begin
      se0_cnt_q <= se0_cnt_q + 1'b1;
    end
  end

  // Mask registers, all zero after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mmsk_q <= RST_BYTE;
      amsk_q <= RST_BYTE;
      tmsk_q <= RST_BYTE;
      rmsk_q <= RST_BYTE;
      nmsk_q <= RST_BYTE;
      fmsk_q <= RST_BYTE;
    end else begin
      if (ws_mmsk) mmsk_q <= wbyte_q;
      if (ws_amsk) amsk_q <= wbyte_q & ALT_BITS;
      if (ws_tmsk) tmsk_q <= wbyte_q;
      if (ws_rmsk) rmsk_q <= wbyte_q;
      if (ws_nmsk) nmsk_q <= wbyte_q;
      if (ws_fmsk) fmsk_q <= wbyte_q & FW_BITS;
    end
  end

  // Event registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mev_q <= RST_BYTE;
      bus_condition_event_q <= RST_BYTE;
      nakev_q <= RST_BYTE;
      rxovr_q <= 4'h0;
      fw_prev_q <= RST_BYTE;
      // Track the live level so an unlocked timer gives no false change after reset
      ul_prev_q <= frame_unlocked_status;
    end else begin
      mev_q <= mev_d;
      bus_condition_event_q <= bus_condition_event_d;
      nakev_q <= nakev_d;
      rxovr_q <= rxovr_d;
      fw_prev_q <= fw_lvl;
      ul_prev_q <= frame_unlocked_status;
    end
  end

  // Interrupt, gated by master enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= mmsk_q[MB_MIE] & (|(mev_q[6:0] & mmsk_q[6:0]));
    end
  end

  // Node state; a module reset lands in bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nfs_q <= state_bus_reset;
      ctl_q <= '{ep_disable: 1'b1, ep_freeze: 1'b0, xcvr_suspend: 1'b0, drive_k: 1'b0};
    end else begin
      nfs_q <= nfs_d;
      ctl_q.ep_disable <= (nfs_d == state_bus_reset);
      ctl_q.ep_freeze <= (nfs_d == state_suspend);
      ctl_q.xcvr_suspend <= (nfs_d == state_suspend);
      ctl_q.drive_k <= (nfs_d == state_wakeup_signalling);
    end
  end

  // Outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign node_state_field = nfs_q;
  assign node_ctl = ctl_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// >>> dv/une_chk.sv
`timescale 1ns/1ns
`default_nettype none
module une_chk import une_pkg::*; (
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic [31:0] rdata, // Read data
  input wire logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [1:0] node_state_field, // Node state
  input wire une_node_s node_ctl, // Node controls
  input wire logic irq // Interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic mie_q; // Shadow of master enable
  logic mie_d; // Its next value
  // Shadow only sees writes whose address and data land on one edge
  assign mie_d = (awvalid && awready && wvalid && wready && awaddr == A_MMSK && wstrb[0]) ? wdata[MB_MIE] : mie_q;
  // Shadow register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mie_q <= 1'b0;
    end else begin
      mie_q <= mie_d;
    end
  end
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  property p_rst_entry;
    $rose(aresetn) |-> node_state_field == 2'h0 && node_ctl.ep_disable;
  endproperty
  a_rst_entry: assert property (p_rst_entry) else $error("node not in bus reset after reset");
  property p_pipes_off;
    node_state_field == 2'h0 && $stable(node_state_field) |-> node_ctl.ep_disable;
  endproperty
  a_pipes_off: assert property (p_pipes_off) else $error("pipes enabled in bus reset");
  property p_wakeup_k;
    node_state_field == 2'h1 && $stable(node_state_field) |-> node_ctl.drive_k && !node_ctl.xcvr_suspend;
  endproperty
  a_wakeup_k: assert property (p_wakeup_k) else $error("no K while waking");
  property p_suspend;
    node_state_field == 2'h3 && $stable(node_state_field) |-> node_ctl.xcvr_suspend && node_ctl.ep_freeze;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not applied");
  property p_irq_gate;
    !mie_q ##1 !mie_q ##1 !mie_q |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt with master enable off");
  property p_rev_ro;
    s_rd_take ##0 araddr == A_REV |=> rdata == {28'h0000000, REV_ID};
  endproperty
  a_rev_ro: assert property (p_rev_ro) else $error("bad revision word");
  property p_wr_resp;
    s_wr_take |-> ##[1:2] bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("late write response");
  property p_rd_resp;
    s_rd_take |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("late read data");
  property p_rd_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
endmodule
bind une_top une_chk u_une_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
  .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .node_state_field, .node_ctl, .irq);
`default_nettype wire

// >>> dv/une_host.sv
`timescale 1ns/1ns
`default_nettype none
module une_host import une_pkg::*; (
  input wire logic aclk, // Core clock
  output var une_line_s line_in // Upstream line conditions
);
  initial line_in = '0; // Quiet line at start
  // Hold one line condition for n cycles, then go quiet again
  task automatic hold(input une_line_s v, input int n);
    @(posedge aclk);
    line_in <= v;
    repeat (n) @(posedge aclk);
    line_in <= '0;
  endtask
endmodule
`default_nettype wire

// >>> dv/usb_node_state_events_bench.sv
`timescale 1ns/1ns
`default_nettype none
module usb_node_state_events_bench;
  import une_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, frame_update, frame_unlocked_status;
  logic [7:0] awaddr, araddr, transmit_event_in, nak_pulse, d, m, p;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, node_state_field, r;
  une_line_s line_in; // From host model
  logic [3:0] receive_last_in, receive_overrun_pulse; // Receive sources
  logic [7:0] fifo_warn_in; // Warning levels
  une_node_s node_ctl; // Node controls seen
  int error_cnt, n_compared, alt_m; // Counters, bus condition model
  une_line_s ev [4] = '{4'h8, 4'h4, 4'h1, 4'h2}; // Idle, SE0, end of packet, resume
  int len [4] = '{55, 60, 3, 3}; // Cycles each is held
  logic [7:0] ex [4] = '{8'h30, 8'h40, 8'h08, 8'h80}; // Flags each raises
  // Free-running core clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  une_top #(.IDLE3_CYC_P(30), .IDLE5_CYC_P(50)) u_une_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .line_in, .frame_update, .frame_unlocked_status, .transmit_event_in, .receive_last_in,
    .receive_overrun_pulse, .nak_pulse, .fifo_warn_in, .node_state_field, .node_ctl, .irq);
  une_host u_une_host (.aclk, .line_in);
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A used-up wait bound ends the run
  task automatic timeout(input int i);
    if (i >= 50) begin
      error_cnt++;
      summarize();
    end
  endtask
  // Write one register; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(RESP_OK));
    timeout(i);
  endtask
  // Read one register; rready may lag to stall the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] e);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        rready <= 1'($urandom);
      end
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    v = rdata[7:0];
    e = rresp;
    timeout(i);
  endtask
  // Read and compare the low byte
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    rd(a, d, r);
    chk(32'(d), 32'(x));
  endtask
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, frame_update, frame_unlocked_status, aresetn} = '0;
    {awaddr, araddr, transmit_event_in, nak_pulse, wdata} = '0;
    {receive_last_in, receive_overrun_pulse, fifo_warn_in} = '0;
    wstrb = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    alt_m = 0;
    void'($urandom(32'h62DF4037));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(A_REV, {4'h0, REV_ID});
    rc(A_MEV, 8'h00);
    rc(A_MMSK, 8'h00);
    rc(A_AMSK, 8'h00);
    rc(A_TX, 8'h00);
    rd(8'h3C, d, r);
    chk(32'(r), 32'(RESP_ERR));
    wr(A_REV, 8'hFF);
    rc(A_REV, {4'h0, REV_ID});
    wr(A_AMSK, 8'hFF);
    rc(A_AMSK, ALT_BITS);
    // Every node state; wake-up and bus reset held past their minimum
    for (int s = 0; s < 4; s++) begin
      wr(A_NFS, 8'(s));
      repeat (s == 1 ? 20001 : (s == 0 ? 2001 : 3)) @(posedge aclk);
      chk(32'({node_ctl.ep_disable, node_ctl.ep_freeze, node_ctl.xcvr_suspend, node_ctl.drive_k,
        node_state_field}), 32'({s == 0, s == 3, s == 3, s == 1, 2'(s)}));
      rc(A_NFS, 8'(s));
    end
    // Each bus condition, raised while suspended, with interrupt on
    wr(A_MMSK, 8'h82);
    for (int k = 0; k < 4; k++) begin
      u_une_host.hold(ev[k], len[k]);
      alt_m = alt_m | ex[k];
      repeat (5) @(posedge aclk);
      chk(32'(irq), 32'h1);
      rc(A_ALT, alt_m[7:0]);
      alt_m = 0;
      rc(A_ALT, 8'h00);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0);
    end
    // Resume outside suspend leaves no flag
    wr(A_NFS, 8'h02);
    u_une_host.hold(4'h2, 3);
    repeat (5) @(posedge aclk);
    rc(A_ALT, 8'h00);
    // Frame, lock change and random NAK events
    m = 8'($urandom);
    p = 8'($urandom);
    wr(A_NMSK, m);
    frame_update <= 1'b1;
    frame_unlocked_status <= 1'b1;
    nak_pulse <= p;
    @(posedge aclk);
    frame_update <= 1'b0;
    nak_pulse <= 8'h00;
    repeat (3) @(posedge aclk);
    rc(A_MEV, {3'h1, |(p & m), 4'h8});
    rc(A_NAK, p);
    rc(A_MEV, 8'h00);
    chk(32'(irq), 32'h0);
    // Transmit summary follows its source level, not reads
    wr(A_TMSK, 8'h01);
    transmit_event_in <= 8'h01;
    repeat (3) @(posedge aclk);
    rc(A_MEV, 8'h04);
    rc(A_TX, 8'h01);
    rc(A_MEV, 8'h04);
    transmit_event_in <= 8'h00;
    repeat (3) @(posedge aclk);
    rc(A_MEV, 8'h00);
    // Write with lane 0 off is ignored
    wstrb <= 4'hE;
    wr(A_TMSK, 8'hFF);
    wstrb <= 4'hF;
    rc(A_TMSK, 8'h01);
    // Warning summary on a new masked level; ignored bits stay out
    wr(A_FMSK, 8'hFF);
    rc(A_FMSK, FW_BITS);
    fifo_warn_in <= 8'h02;
    repeat (3) @(posedge aclk);
    rc(A_MEV, 8'h01);
    rc(A_FW, 8'h02);
    rc(A_MEV, 8'h00);
    fifo_warn_in <= 8'h11;
    repeat (3) @(posedge aclk);
    rc(A_FW, 8'h00);
    rc(A_MEV, 8'h00);
    fifo_warn_in <= 8'h00;
    // Receive summary holds until the overrun is read away
    wr(A_RMSK, 8'h10);
    receive_overrun_pulse <= 4'h1;
    @(posedge aclk);
    receive_overrun_pulse <= 4'h0;
    repeat (3) @(posedge aclk);
    rc(A_MEV, 8'h40);
    rc(A_RX, 8'h10);
    rc(A_MEV, 8'h00);
    // Masked-out receive-last leaves the summary clear
    receive_last_in <= 4'h2;
    repeat (3) @(posedge aclk);
    rc(A_MEV, 8'h00);
    rc(A_RX, 8'h02);
    receive_last_in <= 4'h0;
    summarize();
  end
endmodule
`default_nettype wire
